// ---- common/prmi_consts.svh ----
// constants for the paged register map with identification registers
`ifndef PRMI_CONSTS_SVH
`define PRMI_CONSTS_SVH

// ----------------------------------------------------------------
// map geometry
// ----------------------------------------------------------------
`define PRMI_PAGE_SIZE       256
`define PRMI_OFS_SIL_REV     8'h00
`define PRMI_OFS_PAGE_SEL    8'h01
`define PRMI_OFS_PN_LOW      8'h02
`define PRMI_OFS_PN_HIGH     8'h03
`define PRMI_OFS_GRADE       8'h04
`define PRMI_OFS_DEV_REV     8'h05
`define PRMI_OFS_TOOL0       8'h06
`define PRMI_OFS_TOOL1       8'h07
`define PRMI_OFS_TOOL2       8'h08
`define PRMI_OFS_READY       8'hFE
`define PRMI_OFS_FLAGS       8'h11
`define PRMI_OFS_CTRL        8'h1F

// ----------------------------------------------------------------
// field layout and masks
// ----------------------------------------------------------------
`define PRMI_SIL_REV_MASK    8'h0F
`define PRMI_CTRL_OUT_EN     0
`define PRMI_CTRL_SC_BIT     1

// ----------------------------------------------------------------
// reset values (base device; nvm image may override)
// ----------------------------------------------------------------
`define PRMI_RST_PAGE        8'h00
`define PRMI_RST_CTRL        8'h00
`define PRMI_GRADE_H         8'h07

// ----------------------------------------------------------------
// controller register port offsets
// ----------------------------------------------------------------
`define PRMI_CMD_ADDR        2'h0
`define PRMI_CMD_DATA        2'h1
`define PRMI_CMD_GO          2'h2
`define PRMI_CMD_STAT        2'h3

`endif

// ---- common/prmi_pkg.sv ----
// types for the paged register map
package prmi_pkg;
  typedef logic [7:0]  prmi_byte_t;
  typedef logic [15:0] prmi_addr_t;
  typedef enum logic [1:0] {PRMI_IDLE, PRMI_WAIT, PRMI_DONE} prmi_ctl_e;
endpackage : prmi_pkg

// ---- common/prmi_if.sv ----
// link between host controller and register map device
`timescale 1ns/1ps
interface prmi_if;
  logic       wr;
  logic       rd;
  logic [7:0] ofs;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev  (input wr, input rd, input ofs, input wdata, output rdata);
  modport host (output wr, output rd, output ofs, output wdata,
                input rdata);
endinterface : prmi_if

// ---- hw/prmi_page_decode.sv ----
// page implemented decode and flat address former
`timescale 1ns/1ps
module prmi_page_decode
  import prmi_pkg::*;
(
  input  wire prmi_pkg::prmi_byte_t page_i,
  input  wire prmi_pkg::prmi_byte_t ofs_i,
  output logic                      impl_o,
  output prmi_pkg::prmi_addr_t      addr_o
);
  import prmi_pkg::*;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic page_impl(input prmi_byte_t p);
    page_impl = (p == 8'h00) || (p == 8'h01) || (p == 8'h02) ||
                (p == 8'h03) || (p == 8'h05) || (p == 8'h09); // R2
  endfunction : page_impl

  assign impl_o = page_impl(page_i);
  assign addr_o = {page_i, ofs_i}; // R21
endmodule : prmi_page_decode

// ---- hw/prmi_device.sv ----
// paged register map device with identification registers
`timescale 1ns/1ps
// Functional notes
// R1: pages of 256 byte registers, sparse
// R2: only pages 0,1,2,3,5,9 implemented
// R3: page select at offset 1 everywhere
// R4: page select reads back, write switches
// R5: page 0 offset FE reports ready
// R6: sticky bits clear on written zero
// R7: self-clearing bit drops after action
// R8: reset values come from nvm image
// R9: base part powers up outputs off
// R10: base defaults crystal 48MHz, 1.8V io
// R11: programmed part loads full nvm config
// R12: volatile writes act without nvm commit
// R13: burn sequence saves config to nvm
// R14: host avoids undocumented locations; the host offset register takes any value written
// R15: offset 0 holds 4-bit silicon revision
// R16: offsets 2,3 hold bcd part number
// R17: offset 4 grade letter index
// R18: offset 5 revision letter index
// R19: offsets 6-8 writable tool version
// R20: read-only writes ignored, unused reads zero
// R21: address is page byte then offset
`include "prmi_consts.svh"
module prmi_device
  import prmi_pkg::*;
#(
  parameter logic [3:0]  SIL_REV    = 4'h0,      // arbitrary
  parameter logic [15:0] PART_BCD   = 16'h1234,  // arbitrary
  parameter logic [7:0]  GRADE      = 8'h00,
  parameter logic [7:0]  DEV_REV    = 8'h00,
  parameter logic [23:0] NVM_TOOL   = 24'h00_0000,
  parameter logic [7:0]  NVM_CTRL   = 8'h00,
  parameter logic        XTAL_48M   = 1'b1,
  parameter logic        IO_1V8     = 1'b1
)(
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  prmi_if.dev                bus,
  input  wire logic          ready_i,
  input  wire logic [5:0]    event_i,
  input  wire logic          sc_done_i,
  input  wire logic          burn_i,
  output logic               out_en_o,
  output logic               sc_trig_o,
  output logic               xtal_48m_o,
  output logic               io_1v8_o,
  output logic [23:0]        burn_tool_o,
  output logic               burn_o
);
  import prmi_pkg::*;

  // letter index stops at h; wider codes have no decode
  if (GRADE > 8'h07 && GRADE != `PRMI_GRADE_H) begin : g_grade_chk
    $error("grade out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prmi_byte_t  page_r;
  logic [23:0] tool_r;
  prmi_byte_t  ctrl_r;
  logic [5:0]  flag_r;
  prmi_byte_t  rdata_r;
  logic        impl;
  prmi_addr_t  flat;
  logic        ready_s1_r;
  logic        ready_s2_r;
  logic [5:0]  ev_s1_r;
  logic [5:0]  ev_s2_r;

  prmi_page_decode u_dec (
    .page_i (page_r),
    .ofs_i  (bus.ofs),
    .impl_o (impl),
    .addr_o (flat)
  );

  wire logic on_p0 = impl && (flat[15:8] == 8'h00);
  wire logic wr_go = ce_i && bus.wr;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ready_s1_r <= 1'b0;
      ready_s2_r <= 1'b0;
      ev_s1_r    <= 6'h00;
      ev_s2_r    <= 6'h00;
    end else if (ce_i) begin
      ready_s1_r <= ready_i;
      ready_s2_r <= ready_s1_r;
      ev_s1_r    <= event_i;
      ev_s2_r    <= ev_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // page select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      page_r <= `PRMI_RST_PAGE;
    end else if (wr_go && bus.ofs == `PRMI_OFS_PAGE_SEL) begin
      page_r <= bus.wdata; // R3 R4
    end
  end

  // ----------------------------------------------------------------
  // tool version, loaded from nvm image at reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tool_r <= NVM_TOOL; // R8 R11
    end else if (wr_go && on_p0) begin
      case (bus.ofs)
        `PRMI_OFS_TOOL0: tool_r[7:0]   <= bus.wdata; // R19 R12
        `PRMI_OFS_TOOL1: tool_r[15:8]  <= bus.wdata; // R19
        `PRMI_OFS_TOOL2: tool_r[23:16] <= bus.wdata; // R19
        default:         tool_r        <= tool_r; // R20
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control: output enable and self-clearing trigger
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_r <= NVM_CTRL; // R8 R9
    end else if (ce_i) begin
      if (wr_go && on_p0 && bus.ofs == `PRMI_OFS_CTRL) begin
        ctrl_r <= bus.wdata & 8'h03;
      end else if (sc_done_i) begin
        ctrl_r[`PRMI_CTRL_SC_BIT] <= 1'b0; // R7
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky flags: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flag_r <= 6'h00;
    end else if (ce_i) begin
      if (wr_go && on_p0 && bus.ofs == `PRMI_OFS_FLAGS) begin
        flag_r <= (flag_r & bus.wdata[5:0]) | ev_s2_r; // R6
      end else begin
        flag_r <= flag_r | ev_s2_r; // R6
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      rdata_r <= 8'h00; // R20
      if (bus.rd && bus.ofs == `PRMI_OFS_PAGE_SEL) begin
        rdata_r <= page_r; // R3 R4
      end else if (bus.rd && on_p0) begin // R1
        case (bus.ofs)
          `PRMI_OFS_SIL_REV: rdata_r <= {4'h0, SIL_REV}; // R15
          `PRMI_OFS_PN_LOW:  rdata_r <= PART_BCD[7:0]; // R16
          `PRMI_OFS_PN_HIGH: rdata_r <= PART_BCD[15:8]; // R16
          `PRMI_OFS_GRADE:   rdata_r <= GRADE; // R17
          `PRMI_OFS_DEV_REV: rdata_r <= DEV_REV; // R18
          `PRMI_OFS_TOOL0:   rdata_r <= tool_r[7:0];
          `PRMI_OFS_TOOL1:   rdata_r <= tool_r[15:8];
          `PRMI_OFS_TOOL2:   rdata_r <= tool_r[23:16];
          `PRMI_OFS_FLAGS:   rdata_r <= {2'b00, flag_r};
          `PRMI_OFS_CTRL:    rdata_r <= ctrl_r;
          `PRMI_OFS_READY:   rdata_r <= {7'h00, ready_s2_r}; // R5
          default:           rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      burn_o      <= 1'b0;
      burn_tool_o <= 24'h00_0000;
    end else if (ce_i) begin
      burn_o      <= burn_i; // R13
      burn_tool_o <= burn_i ? tool_r : burn_tool_o; // R13
    end
  end

  assign bus.rdata  = rdata_r;
  assign out_en_o   = ctrl_r[`PRMI_CTRL_OUT_EN]; // R9
  assign sc_trig_o  = ctrl_r[`PRMI_CTRL_SC_BIT];
  assign xtal_48m_o = XTAL_48M; // R10
  assign io_1v8_o   = IO_1V8; // R10
endmodule : prmi_device

// ---- hw/prmi_host.sv ----
// host controller driving the paged register map
`timescale 1ns/1ps
`include "prmi_consts.svh"
module prmi_host
  import prmi_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  prmi_if.host            link
);
  import prmi_pkg::*;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic [7:0] ofs_r;
  logic [7:0] dat_r;
  logic [7:0] res_r;
  logic [7:0] rdata_r;
  logic       lwr_r;
  logic       lrd_r;
  prmi_ctl_e  st_r;

  // go data: bit0 write, bit1 read; the offset register takes any value written, documented or not
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ofs_r <= 8'h00;
      dat_r <= 8'h00;
    end else if (ce_i && wr_i) begin
      if (addr_i == `PRMI_CMD_ADDR) ofs_r <= wdata_i; // R14
      if (addr_i == `PRMI_CMD_DATA) dat_r <= wdata_i; // R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r  <= PRMI_IDLE;
      lwr_r <= 1'b0;
      lrd_r <= 1'b0;
      res_r <= 8'h00;
    end else if (ce_i) begin
      lwr_r <= 1'b0;
      lrd_r <= 1'b0;
      case (st_r)
        PRMI_IDLE: begin
          if (wr_i && addr_i == `PRMI_CMD_GO && st_r == PRMI_IDLE) begin
            lwr_r <= wdata_i[0];
            lrd_r <= wdata_i[1] & ~wdata_i[0];
            st_r  <= wdata_i[1] & ~wdata_i[0] ? PRMI_WAIT : PRMI_IDLE;
          end
        end
        PRMI_WAIT: st_r <= PRMI_DONE;
        PRMI_DONE: begin
          res_r <= link.rdata;
          st_r  <= PRMI_IDLE;
        end
        default: st_r <= PRMI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i && rd_i) begin
      case (addr_i)
        `PRMI_CMD_ADDR: rdata_r <= ofs_r;
        `PRMI_CMD_DATA: rdata_r <= res_r;
        `PRMI_CMD_STAT: rdata_r <= {7'h00, st_r != PRMI_IDLE};
        default:        rdata_r <= 8'h00;
      endcase
    end
  end

  assign rdata_o    = rdata_r;
  assign link.wr    = lwr_r;
  assign link.rd    = lrd_r;
  assign link.ofs   = ofs_r;
  assign link.wdata = dat_r;
endmodule : prmi_host

// ---- dv/prmi_assertions.sv ----
// link checker for the paged register map pair
`timescale 1ns/1ps
module prmi_assertions #(
  parameter logic [3:0]  SIL_REV  = 4'h0,
  parameter logic [15:0] PART_BCD = 16'h1234,
  parameter logic [7:0]  GRADE    = 8'h00,
  parameter logic [7:0]  DEV_REV  = 8'h00,
  parameter logic [23:0] NVM_TOOL = 24'h00_0000
)(
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] ofs,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // ------------------------------------------------------------
  // shadow of page and first tool byte
  // ------------------------------------------------------------
  logic [7:0] pg_r;
  logic [7:0] tool_r;
  logic       p0;
  logic       imp;
  assign p0  = pg_r == 8'h00;
  assign imp = pg_r inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h09};
  // the bench drops ce_i only for one host port write, with no link strobe live, so every strobe counts
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pg_r   <= 8'h00;
      tool_r <= NVM_TOOL[7:0];
    end else begin
      if (wr && ofs == 8'h01) pg_r <= wdata;
      if (wr && p0 && ofs == 8'h06) tool_r <= wdata;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence rd_at(logic [7:0] o);
    rd && p0 && ofs == o;
  endsequence
  chk_page_readback: assert property (
    rd && ofs == 8'h01 |=> rdata == $past(pg_r))
    else $error("page select readback differs");
  chk_unimpl_zero: assert property (
    rd && ofs != 8'h01 && !imp |=> rdata == 8'h00)
    else $error("unimplemented page read not zero");
  chk_sil_rev: assert property (
    rd_at(8'h00) |=> rdata == {4'h0, SIL_REV})
    else $error("silicon revision wrong");
  chk_part_num: assert property (
    rd && p0 && ofs inside {8'h02, 8'h03} |=>
    rdata == ($past(ofs[0]) ? PART_BCD[15:8] : PART_BCD[7:0]))
    else $error("part number byte wrong");
  chk_grade_idx: assert property (
    rd_at(8'h04) |=> rdata == GRADE) else $error("grade wrong");
  chk_dev_rev: assert property (
    rd_at(8'h05) |=> rdata == DEV_REV) else $error("revision wrong");
  chk_ready_bits: assert property (
    rd_at(8'hFE) |=> rdata[7:1] == 7'h00)
    else $error("ready register spare bits set");
  chk_tool_rw: assert property (
    rd_at(8'h06) |=> rdata == $past(tool_r))
    else $error("tool byte readback differs");
endmodule : prmi_assertions

// ---- dv/tb.sv ----
// bench driving host side and device pins of the register map pair
`timescale 1ns/1ps
module tb;
  import prmi_pkg::*;
  localparam logic [15:0] PART = 16'h2468;
  localparam logic [7:0]  GRD  = 8'h07;
  localparam logic [23:0] TOOL = 24'h12_3456;
  localparam logic [7:0]  OT [8] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05,
                                     8'h06, 8'h07, 8'h08};
  localparam logic [7:0]  ID [8] = '{8'h00, PART[7:0], PART[15:8], GRD,
                                     8'h00, TOOL[7:0], TOOL[15:8],
                                     TOOL[23:16]};
  localparam logic [7:0]  PG [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                     8'h09, 8'hFF};
  logic        clk_i     = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        ce_i      = 1'b1;
  logic [1:0]  addr_i    = 2'h0;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        rd_q      = 1'b0;
  logic        ready_i   = 1'b1;
  logic [5:0]  event_i   = 6'h00;
  logic        sc_done_i = 1'b0;
  logic        burn_i    = 1'b0;
  logic [7:0]  rdata_o;
  logic        out_en_o, sc_trig_o, xtal_48m_o, io_1v8_o, burn_o;
  logic [23:0] burn_tool_o;
  logic [7:0]  w;
  logic [7:0]  tw [3];
  logic [7:0]  exp_q [$];
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  prmi_if link_if ();
  prmi_device #(.PART_BCD(PART), .GRADE(GRD), .NVM_TOOL(TOOL))
    prmi_device_inst (.clk_i, .resetn_i, .ce_i, .bus(link_if), .ready_i,
    .event_i, .sc_done_i, .burn_i, .out_en_o, .sc_trig_o, .xtal_48m_o,
    .io_1v8_o, .burn_tool_o, .burn_o);
  prmi_host prmi_host_inst (.clk_i, .resetn_i, .ce_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .link(link_if));
  prmi_assertions #(.PART_BCD(PART), .GRADE(GRD), .NVM_TOOL(TOOL))
    prmi_assertions_inst (.clk_i, .resetn_i, .wr(link_if.wr),
    .rd(link_if.rd), .ofs(link_if.ofs), .wdata(link_if.wdata),
    .rdata(link_if.rdata));
  always #10 clk_i = ~clk_i;
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ------------------------------------------------------------
  // host port cycles
  // ------------------------------------------------------------
  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : hw
  task automatic hr(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : hr
  // go is never issued while busy, so four idle cycles are waited out
  task automatic dw(input logic [7:0] o, input logic [7:0] d);
    hw(2'h0, o);
    hw(2'h1, d);
    hw(2'h2, 8'h01);
    repeat (4) @(posedge clk_i);
  endtask : dw
  task automatic dr(input logic [7:0] o, input logic [7:0] e);
    hw(2'h0, o);
    hw(2'h2, 8'h02);
    repeat (4) @(posedge clk_i);
    hr(2'h1, e);
  endtask : dr
  always @(posedge clk_i) begin
    if (rd_q) chk(rdata_o, exp_q.pop_front());
    rd_q <= rd_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    void'($urandom(56920));
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk({5'h00, out_en_o, xtal_48m_o, io_1v8_o}, 8'h03);
    dr(8'h01, 8'h00);
    dr(8'hFE, 8'h01);
    for (int i = 0; i < 8; i++) begin
      dr(OT[i], ID[i]);
      w = 8'($urandom);
      if (i > 4) tw[i-5] = w;
      dw(OT[i], w);
      dr(OT[i], i > 4 ? w : ID[i]);
    end
    event_i <= 6'h3F;
    repeat (4) @(posedge clk_i);
    event_i <= 6'h00;
    repeat (4) @(posedge clk_i);
    dr(8'h11, 8'h3F);
    dw(8'h11, 8'hFF);
    dr(8'h11, 8'h3F);
    w = 8'($urandom);
    dw(8'h11, w);
    dr(8'h11, w & 8'h3F);
    ready_i <= 1'b0;
    dr(8'hFE, 8'h00);
    ready_i <= 1'b1;
    // busy shows while a read is still in flight
    hw(2'h0, 8'h04);
    hw(2'h2, 8'h02);
    hr(2'h3, 8'h01);
    hr(2'h1, GRD);
    hr(2'h3, 8'h00);
    dw(8'h1F, 8'h03);
    chk({6'h00, sc_trig_o, out_en_o}, 8'h03);
    sc_done_i <= 1'b1;
    @(posedge clk_i);
    sc_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({6'h00, sc_trig_o, out_en_o}, 8'h01);
    dr(8'h1F, 8'h01);
    foreach (PG[j]) begin
      dw(8'h01, PG[j]);
      dr(8'h01, PG[j]);
      dw(8'h06, 8'($urandom));
      dr(8'h02, 8'h00);
    end
    dw(8'h01, 8'h00);
    dr(8'h06, tw[0]);
    // a strobe while the enable is low must not touch the host
    ce_i <= 1'b0;
    hw(2'h0, 8'h55);
    ce_i <= 1'b1;
    hr(2'h0, 8'h06);
    burn_i <= 1'b1;
    @(posedge clk_i);
    burn_i <= 1'b0;
    #1;
    chk({7'h00, burn_o}, 8'h01);
    for (int k = 0; k < 3; k++) chk(burn_tool_o[8*k +: 8], tw[k]);
    close_out();
  end
endmodule : tb
